// ---- cosl_pkg.sv ----
// Function
// - Software, auto-lock, multifunction pin and store triggers are ORed into one primary sync.
// - A multifunction pin trigger acts on the falling edge of its selected signal.
// - Software sets then clears the sync bit; the one-to-zero change is the event.
// - Frequency or phase lock can raise a primary sync, enabled per lock type.
// - Sync source 00: falling edge of primary sync directly restarts the outputs.
// - Sync source 01: primary rising edge arms wait for next active reference rising edge.
// - Sync source 10: primary rising edge arms wait for a feedback rollover.
// - Arming drives the detector output high, stalling every unmasked divider at once.
// - Awaited reference edge drops the detector output, restarting the dividers aligned.
// - The reference edge detector follows the active reference without software selection.
// - Sync release is reclocked into the divider clock before dividers restart.
// - Reference-aligned sync is one open-loop event, no later tracking of drift.
// - Each channel has a mask bit; a masked channel ignores synchronization.
// - Masked channels keep running while unmasked ones stay stalled.
// - A settings bit picks internal or external current set resistor.
// - Mode bit 3 picks low (0) or high (1) drive current per channel.
// - Each divider divides by its programmed value plus one; a value of 0 toggles and divides by two.
// - Enable changes take effect on period boundaries, so equal dividers switch together.
package cosl_pkg;

    localparam int APB_AW = 16;
    localparam int IDX_W  = 12;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } cosl_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } cosl_apb_rsp_t;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DIST_SETTINGS = 12'h400;
    localparam logic [IDX_W-1:0] IDX_OUT_ENABLE    = 12'h401;
    localparam logic [IDX_W-1:0] IDX_SYNC_CTL      = 12'h402;
    localparam logic [IDX_W-1:0] IDX_AUTO_SYNC     = 12'h403;
    localparam logic [IDX_W-1:0] IDX_CH0_MODE      = 12'h404;
    localparam logic [IDX_W-1:0] IDX_CH1_MODE      = 12'h405;
    localparam logic [IDX_W-1:0] IDX_DIV_Q0        = 12'h410;
    localparam logic [IDX_W-1:0] IDX_DIV_Q1        = 12'h411;
    localparam logic [IDX_W-1:0] IDX_SYNC_STATUS   = 12'h412;
    localparam logic [IDX_W-1:0] IDX_SYNC_TRIG     = 12'ha02;

    // Field positions
    localparam int BIT_HF_RX      = 4;
    localparam int BIT_EXT_RSET   = 5;
    localparam int BIT_SRC_LO     = 4;
    localparam int BIT_SW_SYNC    = 1;
    localparam int BIT_AUTO_FREQ  = 0;
    localparam int BIT_AUTO_PHASE = 1;
    localparam int BIT_DRIVE      = 3;
    localparam int BIT_POL_INV    = 4;

    // Reset values
    localparam logic [7:0] RST_REG8  = 8'h00;
    localparam int         RST_DIVQ  = 0;

    // Restart latency from sync release, in divider clock cycles
    localparam int RECLOCK_CYCLES = 4;

    typedef enum logic [1:0] {
        COSL_SRC_DIRECT = 2'b00,
        COSL_SRC_REF    = 2'b01,
        COSL_SRC_FB     = 2'b10,
        COSL_SRC_RSVD   = 2'b11
    } cosl_src_t;

endpackage

// ---- cosl_top.sv ----
// The APB interface to the registers was chosen for this implementation.
module cosl_top #(
    parameter int DIV_W           = 30,
    parameter int RECLOCK_STAGES  = cosl_pkg::RECLOCK_CYCLES
) (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire cosl_pkg::cosl_apb_req_t apb_req,
    output      cosl_pkg::cosl_apb_rsp_t apb_rsp,
    input  wire logic                    freq_lock,
    input  wire logic                    phase_lock,
    input  wire logic                    mf_sync_sel,
    input  wire logic                    nv_sync,
    input  wire logic [3:0]              ref_in,
    input  wire logic [1:0]              ref_active_sel,
    input  wire logic                    fb_rollover,
    output      logic [1:0]              chan_out,
    output      logic [1:0]              chan_drive_strong,
    output      logic                    current_set_external,
    output      logic                    hf_receiver_sel,
    output      logic                    sync_pulse
);

    generate
        if (DIV_W < 2 || DIV_W > 30)
        begin : g_bad_div
            $error("DIV_W must lie in 2..30");
        end
        if (RECLOCK_STAGES < 2 || RECLOCK_STAGES > 8)
        begin : g_bad_reclock
            $error("RECLOCK_STAGES must lie in 2..8");
        end
    endgenerate

    localparam logic [DIV_W-1:0] ONE_Q  = DIV_W'(1);
    localparam logic [DIV_W-1:0] ZERO_Q = DIV_W'(cosl_pkg::RST_DIVQ);
    localparam int               IDX_W_L      = cosl_pkg::IDX_W;
    localparam int               APB_AW_L     = cosl_pkg::APB_AW;
    // Last stage that still shows a stall one cycle before release
    localparam int               RECLOCK_LAST = RECLOCK_STAGES - 1;

    typedef struct packed {
        logic                        ready;
        logic                        slverr;
        logic [31:0]                 rdata;
        logic [7:0]                  dist_settings;
        logic [1:0]                  out_enable;
        logic [7:0]                  sync_ctl;
        logic [7:0]                  auto_ctl;
        logic [1:0][7:0]             ch_mode;
        logic [7:0]                  trig_ctl;
        logic [1:0][DIV_W-1:0]       divq;
        logic                        mf_q;
        logic                        nv_q;
        logic [1:0]                  lock_q;
        logic                        auto_pulse;
        logic                        prim_q;
        logic                        armed;
        logic                        ref_meta;
        logic                        ref_sync;
        logic                        ref_q;
        logic [RECLOCK_STAGES-1:0]   pipe;
        logic [1:0][DIV_W-1:0]       cnt;
        logic [1:0]                  dout;
        logic [1:0]                  en_eff;
        logic [1:0]                  clk_out;
        logic [7:0]                  sync_count;
    } cosl_state_t;

    localparam cosl_state_t ST_RST = '0;

    cosl_state_t        s;
    cosl_state_t        next_s;
    logic               prim;
    logic               prim_rise;
    logic               prim_fall;
    logic               ref_rise;
    logic               stall_src;
    logic               stall_dly;
    logic [1:0]         chan_stall;
    cosl_pkg::cosl_src_t src;

    assign src       = cosl_pkg::cosl_src_t'(s.sync_ctl[cosl_pkg::BIT_SRC_LO +: 2]);
    // Every trigger source feeds one primary level
    assign prim      = s.trig_ctl[cosl_pkg::BIT_SW_SYNC] | s.mf_q | s.nv_q | s.auto_pulse;
    assign prim_rise = prim & ~s.prim_q;
    // Bit clear and pin fall both show up as a primary fall
    assign prim_fall = ~prim & s.prim_q;
    assign ref_rise  = s.ref_sync & ~s.ref_q;
    // Direct mode stalls while primary is high; armed modes stall while armed
    assign stall_src = ((src == cosl_pkg::COSL_SRC_DIRECT) & prim) | s.armed;
    assign stall_dly = s.pipe[RECLOCK_STAGES-1];
    assign chan_stall = {2{stall_dly}} & ~s.sync_ctl[1:0];

    always_comb
    begin
        logic [IDX_W_L-1:0] idx;
        logic               hit;
        logic [31:0]        rd;
        logic [DIV_W:0]     qp1;
        logic [DIV_W-1:0]   half;
        idx    = apb_req.paddr[2 +: IDX_W_L];
        hit    = 1'b0;
        rd     = 32'h0000_0000;
        qp1    = '0;
        half   = '0;
        next_s = s;

        // Bus slave: decode in setup, answer in access
        next_s.ready  = apb_req.psel & ~apb_req.penable;
        next_s.slverr = 1'b0;
        next_s.rdata  = 32'h0000_0000;
        hit = 1'b1;
        unique case (idx)
            cosl_pkg::IDX_DIST_SETTINGS: rd = {24'h00_0000, s.dist_settings};
            cosl_pkg::IDX_OUT_ENABLE:    rd = {30'h0000_0000, s.out_enable};
            cosl_pkg::IDX_SYNC_CTL:      rd = {24'h00_0000, s.sync_ctl};
            cosl_pkg::IDX_AUTO_SYNC:     rd = {24'h00_0000, s.auto_ctl};
            cosl_pkg::IDX_CH0_MODE:      rd = {24'h00_0000, s.ch_mode[0]};
            cosl_pkg::IDX_CH1_MODE:      rd = {24'h00_0000, s.ch_mode[1]};
            cosl_pkg::IDX_DIV_Q0:        rd = 32'(s.divq[0]);
            cosl_pkg::IDX_DIV_Q1:        rd = 32'(s.divq[1]);
            cosl_pkg::IDX_SYNC_STATUS:   rd = {16'h0000, s.sync_count, 3'h0, s.prim_q, chan_stall,
                                               stall_dly, s.armed};
            cosl_pkg::IDX_SYNC_TRIG:     rd = {24'h00_0000, s.trig_ctl};
            default:                     hit = 1'b0;
        endcase
        if (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[APB_AW_L-1:IDX_W_L+2] != '0)
        begin
            hit = 1'b0;
        end
        if (apb_req.psel && !apb_req.penable)
        begin
            next_s.slverr = ~hit;
            next_s.rdata  = (hit && !apb_req.pwrite) ? rd : 32'h0000_0000;
        end
        if (apb_req.psel && apb_req.penable && s.ready && apb_req.pwrite && !s.slverr)
        begin
            unique case (idx)
                cosl_pkg::IDX_DIST_SETTINGS: next_s.dist_settings = apb_req.pwdata[7:0];
                cosl_pkg::IDX_OUT_ENABLE:    next_s.out_enable    = apb_req.pwdata[1:0];
                cosl_pkg::IDX_SYNC_CTL:      next_s.sync_ctl      = apb_req.pwdata[7:0];
                cosl_pkg::IDX_AUTO_SYNC:     next_s.auto_ctl      = apb_req.pwdata[7:0];
                cosl_pkg::IDX_CH0_MODE:      next_s.ch_mode[0]    = apb_req.pwdata[7:0];
                cosl_pkg::IDX_CH1_MODE:      next_s.ch_mode[1]    = apb_req.pwdata[7:0];
                cosl_pkg::IDX_DIV_Q0:        next_s.divq[0]       = apb_req.pwdata[DIV_W-1:0];
                cosl_pkg::IDX_DIV_Q1:        next_s.divq[1]       = apb_req.pwdata[DIV_W-1:0];
                cosl_pkg::IDX_SYNC_TRIG:     next_s.trig_ctl      = apb_req.pwdata[7:0];
                default:                     next_s.rdata         = 32'h0000_0000;
            endcase
        end

        // Trigger sampling, one level per source
        next_s.mf_q   = mf_sync_sel;
        next_s.nv_q   = nv_sync;
        next_s.lock_q = {phase_lock, freq_lock};
        // A lock arriving makes a one-cycle primary high, whose fall syncs in direct mode
        next_s.auto_pulse = (freq_lock & ~s.lock_q[0] & s.auto_ctl[cosl_pkg::BIT_AUTO_FREQ])
                          | (phase_lock & ~s.lock_q[1] & s.auto_ctl[cosl_pkg::BIT_AUTO_PHASE]);
        next_s.prim_q = prim;

        // Reference path follows the active input on its own
        next_s.ref_meta = ref_in[ref_active_sel];
        next_s.ref_sync = s.ref_meta;
        next_s.ref_q    = s.ref_sync;

        // Armed detector; clears once, then waits for a fresh primary rise
        unique case (src)
            cosl_pkg::COSL_SRC_REF:
            begin
                if (s.armed && ref_rise)
                    next_s.armed = 1'b0;
                else if (prim_rise)
                    next_s.armed = 1'b1;
            end
            cosl_pkg::COSL_SRC_FB:
            begin
                if (s.armed && fb_rollover)
                    next_s.armed = 1'b0;
                else if (prim_rise)
                    next_s.armed = 1'b1;
            end
            cosl_pkg::COSL_SRC_DIRECT:   next_s.armed = 1'b0;
            cosl_pkg::COSL_SRC_RSVD:     next_s.armed = 1'b0;
        endcase

        // Release is delayed through the reclocking stages
        next_s.pipe = {s.pipe[RECLOCK_STAGES-2:0], stall_src};
        if (s.pipe[0] && !stall_src)
            next_s.sync_count = s.sync_count + 8'h01;

        for (int i = 0; i < 2; i++)
        begin
            qp1  = {1'b0, s.divq[i]} + {{DIV_W{1'b0}}, 1'b1};
            half = qp1[DIV_W:1];
            if (chan_stall[i])
            begin
                // Held at period start so all unmasked channels leave together
                next_s.cnt[i]  = ZERO_Q;
                next_s.dout[i] = 1'b0;
            end
            else
            begin
                next_s.cnt[i] = (s.cnt[i] >= s.divq[i]) ? ZERO_Q : s.cnt[i] + ONE_Q;
                // Ratio one cannot pass the clock through a flop; it toggles instead
                if (s.divq[i] == ZERO_Q)
                    next_s.dout[i] = ~s.dout[i];
                else
                    next_s.dout[i] = (next_s.cnt[i] < half);
            end
            // Enables land only at a period start, never mid pulse
            if (chan_stall[i] || next_s.cnt[i] == ZERO_Q)
                next_s.en_eff[i] = s.out_enable[i];
            next_s.clk_out[i] = next_s.en_eff[i] & (next_s.dout[i] ^ s.ch_mode[i][cosl_pkg::BIT_POL_INV]);
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            s <= ST_RST;
        else
            s <= next_s;
    end

    assign apb_rsp.pready        = s.ready;
    assign apb_rsp.prdata        = s.rdata;
    assign apb_rsp.pslverr       = s.slverr;
    assign chan_out              = s.clk_out;
    assign chan_drive_strong     = {s.ch_mode[1][cosl_pkg::BIT_DRIVE], s.ch_mode[0][cosl_pkg::BIT_DRIVE]};
    assign current_set_external  = s.dist_settings[cosl_pkg::BIT_EXT_RSET];
    assign hf_receiver_sel       = s.dist_settings[cosl_pkg::BIT_HF_RX];
    assign sync_pulse            = s.pipe[RECLOCK_STAGES-1];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    AST_OR_SOURCES: assert property ((s.nv_q || s.mf_q || s.auto_pulse) |-> prim)
        else $error("primary sync missed a source");

    AST_PIN_FALL: assert property (($fell(s.mf_q) && !s.nv_q && !s.auto_pulse
                                    && !s.trig_ctl[cosl_pkg::BIT_SW_SYNC]) |-> prim_fall)
        else $error("pin fall did not drop primary sync");

    AST_SW_CLEAR: assert property (($fell(s.trig_ctl[cosl_pkg::BIT_SW_SYNC]) && !s.mf_q && !s.nv_q
                                    && !s.auto_pulse) |-> prim_fall)
        else $error("software bit clear did not drop primary sync");

    AST_AUTO_LOCK: assert property ((!s.lock_q[0] && freq_lock && s.auto_ctl[cosl_pkg::BIT_AUTO_FREQ]
                                     && !s.auto_ctl[cosl_pkg::BIT_AUTO_PHASE])
                                    |=> s.auto_pulse ##1 !s.auto_pulse)
        else $error("lock did not raise an automatic sync");

    AST_DIRECT_STALL: assert property ((src == cosl_pkg::COSL_SRC_DIRECT && prim)
                                       |-> ##RECLOCK_STAGES stall_dly)
        else $error("direct mode did not stall after primary high");

    AST_ARM: assert property ((src == cosl_pkg::COSL_SRC_REF && prim_rise && !s.armed
                               && $stable(src)) |=> s.armed)
        else $error("primary rise did not arm reference detector");

    AST_FB_RELEASE: assert property ((src == cosl_pkg::COSL_SRC_FB && s.armed && fb_rollover)
                                     |=> !s.armed)
        else $error("feedback rollover did not release detector");

    AST_ARMED_STALLS: assert property ((s.armed && !s.sync_ctl[0]) |-> ##RECLOCK_STAGES chan_stall[0])
        else $error("armed detector did not stall channel zero");

    AST_REF_RELEASE: assert property ((src == cosl_pkg::COSL_SRC_REF && s.armed && ref_rise)
                                      |=> !s.armed)
        else $error("reference edge did not release detector");

    AST_RECLOCK: assert property ($fell(stall_src) |-> ##RECLOCK_LAST stall_dly ##1 !stall_dly)
        else $error("sync release latency wrong");

    AST_ONE_SHOT: assert property ((!s.armed && !prim_rise) |=> !s.armed)
        else $error("detector armed without a primary rise");

    AST_MASK: assert property ((s.sync_ctl[1] && $stable(s.divq[1]) && s.cnt[1] < s.divq[1])
                               |=> s.cnt[1] == $past(s.cnt[1]) + ONE_Q)
        else $error("masked channel stopped counting");

    AST_DIV_WRAP: assert property ((!chan_stall[0] && s.cnt[0] >= s.divq[0]) |=> s.cnt[0] == ZERO_Q)
        else $error("divider did not wrap at its programmed value");

    AST_ENABLE_EDGE: assert property ($changed(s.en_eff[0]) |-> (s.cnt[0] == ZERO_Q))
        else $error("enable changed inside a divider period");

    AST_APB_READY: assert property ((apb_req.psel && !apb_req.penable) |=> s.ready ##1 !s.ready
                                    || (apb_req.psel && !apb_req.penable))
        else $error("bus slave did not answer in one cycle");

endmodule

// ---- cosl_pins_model.sv ----
module cosl_pins_model (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic [3:0] ref_req,
    input  wire logic       fb_req,
    output      logic [3:0] ref_in,
    output      logic       fb_rollover
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] high_cnt [4];

    // One short high pulse per request; idle references stay low
    always_ff @(posedge core_clk or negedge nrst)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!nrst)
                high_cnt[i] <= 2'h0;
            else if (ref_req[i])
                high_cnt[i] <= 2'h3;
            else if (high_cnt[i] != 2'h0)
                high_cnt[i] <= high_cnt[i] - 2'h1;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            ref_in[i] = (high_cnt[i] != 2'h0);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            fb_rollover <= 1'b0;
        else
            fb_rollover <= fb_req;
    end
endmodule

// ---- clock_output_sync_logic_bench.sv ----
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %0h seen %0h", nm, e, g); end end

module clock_output_sync_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    core_clk;
    logic                    nrst;
    cosl_pkg::cosl_apb_req_t apb_req;
    cosl_pkg::cosl_apb_rsp_t apb_rsp;
    logic                    freq_lock;
    logic                    phase_lock;
    logic                    mf_sync_sel;
    logic                    nv_sync;
    logic [3:0]              ref_in;
    logic [1:0]              ref_active_sel;
    logic                    fb_rollover;
    logic [1:0]              chan_out;
    logic [1:0]              chan_drive_strong;
    logic                    current_set_external;
    logic                    hf_receiver_sel;
    logic                    sync_pulse;
    logic [3:0]              ref_req;
    logic                    fb_req;
    logic [31:0]             rd;
    logic                    err;
    int                      n_fail;
    int                      n_checks;
    int                      n;
    int                      tog;

    cosl_top u_cosl_top (
        .core_clk             (core_clk),
        .nrst                 (nrst),
        .apb_req              (apb_req),
        .apb_rsp              (apb_rsp),
        .freq_lock            (freq_lock),
        .phase_lock           (phase_lock),
        .mf_sync_sel          (mf_sync_sel),
        .nv_sync              (nv_sync),
        .ref_in               (ref_in),
        .ref_active_sel       (ref_active_sel),
        .fb_rollover          (fb_rollover),
        .chan_out             (chan_out),
        .chan_drive_strong    (chan_drive_strong),
        .current_set_external (current_set_external),
        .hf_receiver_sel      (hf_receiver_sel),
        .sync_pulse           (sync_pulse)
    );

    cosl_pins_model u_cosl_pins_model (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .ref_req     (ref_req),
        .fb_req      (fb_req),
        .ref_in      (ref_in),
        .fb_rollover (fb_rollover)
    );

    task automatic close_out;
    begin
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // Request held until the rising edge that sees pready; an idle cycle follows
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        int i;
    begin
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= {2'b00, idx, 2'b00};
        apb_req.pwdata <= wd;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge core_clk);
            i++;
            if (i > 20)
            begin
                n_fail++;
                close_out();
            end
        end
        while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge core_clk);
    end
    endtask

    task automatic wait_sync(input logic lvl, input int bound);
    begin
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
            if (n > bound)
            begin
                n_fail++;
                close_out();
            end
        end
        while (sync_pulse !== lvl);
        @(posedge core_clk);
    end
    endtask

    task automatic hold(input logic lvl, input int cyc);
    begin
        repeat (cyc)
        begin
            @(negedge core_clk);
            `CHK("sync_pulse hold", lvl, sync_pulse)
        end
        @(posedge core_clk);
    end
    endtask

    task automatic period(input int ch, input int exp);
    begin
        wait_sync(1'b0, 1);
        n = 0;
        while (chan_out[ch] !== 1'b0 && n < 40) begin @(negedge core_clk); n++; end
        while (chan_out[ch] !== 1'b1 && n < 40) begin @(negedge core_clk); n++; end
        n = 0;
        do begin @(negedge core_clk); n++; end while (chan_out[ch] !== 1'b0 && n < 40);
        do begin @(negedge core_clk); n++; end while (chan_out[ch] !== 1'b1 && n < 40);
        `CHK("divider period", exp, n)
        @(posedge core_clk);
    end
    endtask

    task automatic pulse_ref(input logic [3:0] which);
    begin
        ref_req <= which;
        @(posedge core_clk);
        ref_req <= 4'h0;
        @(posedge core_clk);
    end
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial
    begin
        #800000;
        n_fail++;
        close_out();
    end

    initial
    begin
        nrst = 1'b0;
        apb_req = '0;
        {freq_lock, phase_lock, mf_sync_sel, nv_sync, fb_req} = 5'h00;
        ref_active_sel = 2'h0;
        ref_req = 4'h0;
        n_fail = 0;
        n_checks = 0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (int k = 0; k < 6; k++)
        begin
            apb(1'b0, cosl_pkg::IDX_DIST_SETTINGS + 12'(k), 32'h0);
            `CHK("reset value", 32'h0, rd)
        end
        apb(1'b1, cosl_pkg::IDX_DIST_SETTINGS, 32'h30);
        `CHK("external resistor", 1'b1, current_set_external)
        `CHK("hf receiver", 1'b1, hf_receiver_sel)
        apb(1'b1, cosl_pkg::IDX_CH0_MODE, 32'h8);
        `CHK("drive strength", 2'b01, chan_drive_strong)
        apb(1'b1, cosl_pkg::IDX_CH1_MODE, 32'h8);
        apb(1'b0, cosl_pkg::IDX_CH1_MODE, 32'h0);
        `CHK("mode readback", 32'h8, rd)
        `CHK("drive strength", 2'b11, chan_drive_strong)
        apb(1'b0, 12'h406, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        apb(1'b1, cosl_pkg::IDX_DIV_Q0, 32'h3);
        apb(1'b1, cosl_pkg::IDX_DIV_Q1, 32'h5);
        apb(1'b1, cosl_pkg::IDX_OUT_ENABLE, 32'h3);
        period(0, 4);
        period(1, 6);
        apb(1'b1, cosl_pkg::IDX_DIV_Q1, 32'h3);
        // Direct sync with channel one masked
        apb(1'b1, cosl_pkg::IDX_SYNC_CTL, 32'h2);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h2);
        wait_sync(1'b1, 12);
        tog = 0;
        repeat (16)
        begin
            @(negedge core_clk);
            `CHK("stalled channel", 1'b0, chan_out[0])
            tog += int'(chan_out[1]);
        end
        `CHK("masked channel runs", 1'b1, tog > 0)
        @(posedge core_clk);
        apb(1'b0, cosl_pkg::IDX_SYNC_STATUS, 32'h0);
        `CHK("stall status", 4'b1011, rd[4:1])
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h0);
        wait_sync(1'b0, 12);
        `CHK("release delay", 1'b1, n >= 2 && n <= 6)
        // Unmasked sync lines up equal dividers
        apb(1'b1, cosl_pkg::IDX_SYNC_CTL, 32'h0);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h2);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h0);
        wait_sync(1'b0, 16);
        tog = 0;
        repeat (16)
        begin
            @(negedge core_clk);
            `CHK("aligned channels", chan_out[0], chan_out[1])
            tog += int'(chan_out[0]);
        end
        `CHK("aligned duty", 8, tog)
        @(posedge core_clk);
        mf_sync_sel <= 1'b1;
        wait_sync(1'b1, 12);
        mf_sync_sel <= 1'b0;
        wait_sync(1'b0, 12);
        nv_sync <= 1'b1;
        wait_sync(1'b1, 12);
        nv_sync <= 1'b0;
        wait_sync(1'b0, 12);
        apb(1'b1, cosl_pkg::IDX_AUTO_SYNC, 32'h1);
        phase_lock <= 1'b1;
        hold(1'b0, 12);
        freq_lock <= 1'b1;
        wait_sync(1'b1, 12);
        wait_sync(1'b0, 12);
        phase_lock <= 1'b0;
        apb(1'b1, cosl_pkg::IDX_AUTO_SYNC, 32'h2);
        phase_lock <= 1'b1;
        wait_sync(1'b1, 12);
        wait_sync(1'b0, 12);
        // Reference-aligned mode waits on reference two only
        ref_active_sel <= 2'h2;
        apb(1'b1, cosl_pkg::IDX_SYNC_CTL, 32'h10);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h2);
        wait_sync(1'b1, 12);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h0);
        hold(1'b1, 20);
        apb(1'b0, cosl_pkg::IDX_SYNC_STATUS, 32'h0);
        `CHK("armed status", 1'b1, rd[0])
        pulse_ref(4'h1);
        hold(1'b1, 12);
        pulse_ref(4'h4);
        wait_sync(1'b0, 16);
        // Outputs parked and restored only once the sync event is over
        apb(1'b1, cosl_pkg::IDX_OUT_ENABLE, 32'h0);
        apb(1'b1, cosl_pkg::IDX_OUT_ENABLE, 32'h3);
        pulse_ref(4'h4);
        hold(1'b0, 16);
        apb(1'b1, cosl_pkg::IDX_SYNC_CTL, 32'h20);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h2);
        wait_sync(1'b1, 12);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h0);
        hold(1'b1, 16);
        fb_req <= 1'b1;
        @(posedge core_clk);
        fb_req <= 1'b0;
        wait_sync(1'b0, 16);
        apb(1'b1, cosl_pkg::IDX_SYNC_CTL, 32'h30);
        apb(1'b1, cosl_pkg::IDX_SYNC_TRIG, 32'h2);
        hold(1'b0, 12);
        close_out();
    end
endmodule
